// *** rtl/icf_pkg.sv ***
// constants, register map and decode helpers for the interrupt control and flags block
`default_nettype none

package icf_pkg;

	// ==========================================================================
	// register byte offsets on the AXI4-Lite slave
	localparam logic [7:0]  CTRL_OFFSET       = 8'h00;
	localparam logic [7:0]  FLAGS_OFFSET      = 8'h04;
	localparam logic [7:0]  STATUS_OFFSET     = 8'h08;
	localparam logic [7:0]  MASK_OFFSET       = 8'h0c;

	// ==========================================================================
	// control register fields
	localparam int          CTRL_ALT_BIT      = 15;
	localparam int          CTRL_DIS_BIT      = 14;
	localparam int          CTRL_POL_LSB      = 0;
	localparam int          EXT_IRQ_COUNT     = 3;
	localparam logic [15:0] CTRL_WR_MASK      = 16'h8007;
	localparam logic [15:0] CTRL_RESET        = 16'h0000;

	// ==========================================================================
	// flag, status and mask layouts
	localparam logic [15:0] FLAG_IMPL_MASK    = 16'h3fef;
	localparam logic [15:0] FLAG_SRC_MASK     = 16'h3fee;
	localparam int          FLAG_EXT0_BIT     = 0;
	localparam logic [15:0] FLAGS_RESET       = 16'h0000;
	localparam int          STAT_EXT1_BIT     = 14;
	localparam int          STAT_EXT2_BIT     = 15;
	localparam logic [15:0] STATUS_IMPL_MASK  = 16'hffef;
	localparam logic [15:0] STATUS_RESET      = 16'h0000;
	localparam logic [15:0] MASK_RESET        = 16'h0000;

	// ==========================================================================
	// bus answers and vector table bases
	localparam logic [1:0]  RESP_OKAY         = 2'b00;
	localparam logic [1:0]  RESP_SLVERR       = 2'b10;
	localparam logic [15:0] STD_VEC_BASE_DEF  = 16'h0004;
	localparam logic [15:0] ALT_VEC_BASE_DEF  = 16'h0104;

	typedef enum logic [2:0] {
		SEL_NONE,
		SEL_CTRL,
		SEL_FLAGS,
		SEL_STATUS,
		SEL_MASK
	} icf_sel_type;

	// address decode shared by the read and write paths
	function automatic icf_sel_type icf_decode(input logic [7:0] addr);
		case (addr)
			CTRL_OFFSET:   icf_decode = SEL_CTRL;
			FLAGS_OFFSET:  icf_decode = SEL_FLAGS;
			STATUS_OFFSET: icf_decode = SEL_STATUS;
			MASK_OFFSET:   icf_decode = SEL_MASK;
			default:       icf_decode = SEL_NONE;
		endcase
	endfunction

	// byte-lane merge of a write into a 16-bit register
	function automatic logic [15:0] icf_merge(input logic [15:0] old_val,
		input logic [15:0] new_val, input logic [1:0] strb);
		icf_merge = {strb[1] ? new_val[15:8] : old_val[15:8],
			strb[0] ? new_val[7:0] : old_val[7:0]};
	endfunction

endpackage

`default_nettype wire

// *** rtl/icf_evt_if.sv ***
// carrier between the top and its edge detector and interrupt status bank
`default_nettype none

interface icf_evt_if;
	logic [2:0]  pin;
	logic [2:0]  pol;
	logic [2:0]  edge_evt;
	logic [15:0] evt_set;
	logic [15:0] w1c;
	logic        mask_wr;
	logic [15:0] mask_data;
	logic [15:0] status;
	logic [15:0] mask;
	logic        irq;

	modport edge_mp (input pin, input pol, output edge_evt);
	modport irq_mp (input evt_set, input w1c, input mask_wr, input mask_data,
		output status, output mask, output irq);
	modport core_mp (output pin, output pol, input edge_evt, output evt_set,
		output w1c, output mask_wr, output mask_data, input status, input mask,
		input irq);
endinterface

`default_nettype wire

// *** rtl/icf_edge_detect.sv ***
// synchronisers and polarity-selectable edge detection for the external interrupt pins
`default_nettype none

module icf_edge_detect
	import icf_pkg::*;
(
	// clock and reset
	input  wire logic  clock_i,
	input  wire logic  sys_rst_i,
	// pins in, events out
	icf_evt_if.edge_mp evt
);

	// ==========================================================================
	// two-stage synchroniser plus one history stage
	logic [2:0] sync1;
	logic [2:0] sync2;
	logic [2:0] sync3;

	// sync1 feeds sync2 only; a pin held high through reset shows one rising edge
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sync1 <= 3'h0;
			sync2 <= 3'h0;
			sync3 <= 3'h0;
		end else begin
			sync1 <= evt.pin;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// polarity one picks the falling edge, zero the rising edge
	always_comb begin
		evt.edge_evt = (sync3 & ~sync2 & evt.pol) | (~sync3 & sync2 & ~evt.pol);
	end

	// ==========================================================================
	// checks
	chk_fall_edge_one: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		($fell(evt.pin[1]) && evt.pol[1]) ##1 evt.pol[1] ##1 evt.pol[1] |-> evt.edge_evt[1])
		else $error("falling edge on pin 1 not detected");
	chk_fall_edge_two: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		($fell(evt.pin[2]) && evt.pol[2]) ##1 evt.pol[2] ##1 evt.pol[2] |-> evt.edge_evt[2])
		else $error("falling edge on pin 2 not detected");
	chk_rise_edge_zero: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		($rose(evt.pin[0]) && !evt.pol[0]) ##1 !evt.pol[0] ##1 !evt.pol[0]
		|-> evt.edge_evt[0] ##1 !evt.edge_evt[0])
		else $error("rising edge on pin 0 not a single pulse");

endmodule

`default_nettype wire

// *** rtl/icf_irq_bank.sv ***
// sticky event status, mask and the level interrupt output
`default_nettype none

module icf_irq_bank
	import icf_pkg::*;
(
	// clock and reset
	input  wire logic clock_i,
	input  wire logic sys_rst_i,
	// events, clears and mask writes
	icf_evt_if.irq_mp evt
);

	// ==========================================================================
	// status: a new event beats a clear arriving in the same cycle
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			evt.status <= STATUS_RESET;
		end else begin
			evt.status <= ((evt.status & ~evt.w1c) | evt.evt_set) & STATUS_IMPL_MASK;
		end
	end

	// mask, same layout as status
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			evt.mask <= MASK_RESET;
		end else if (evt.mask_wr) begin
			evt.mask <= evt.mask_data & STATUS_IMPL_MASK;
		end
	end

	// level output, no extra cycle of latency
	always_comb begin
		evt.irq = |(evt.status & evt.mask);
	end

	// ==========================================================================
	// checks
	chk_irq_follows_event: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		((evt.evt_set & evt.mask & STATUS_IMPL_MASK) != 16'h0000 && !evt.mask_wr) |=> evt.irq)
		else $error("unmasked event did not raise the interrupt");
	chk_status_sticky: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		(evt.status[13] && !evt.w1c[13]) |=> evt.status[13] [*1])
		else $error("status bit dropped without a clear");

endmodule

`default_nettype wire

// *** rtl/icf_top.sv ***
// interrupt control and request flag registers behind an AXI4-Lite slave
`default_nettype none

module icf_top
	import icf_pkg::*;
#(
	parameter logic [15:0] STD_VEC_BASE = STD_VEC_BASE_DEF,
	parameter logic [15:0] ALT_VEC_BASE = ALT_VEC_BASE_DEF
) (
	// clock and reset
	input  wire logic        clock_i,
	input  wire logic        sys_rst_i,
	// axi4-lite write address and data
	input  wire logic [7:0]  s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	// axi4-lite write response
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	// axi4-lite read
	input  wire logic [7:0]  s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	// external interrupt pins and peripheral request pulses
	input  wire logic [2:0]  ext_irq_pin_i,
	input  wire logic [15:0] periph_event_i,
	input  wire logic        disable_instr_active_i,
	// outputs to the core
	output logic [2:0]       ext_irq_event_o,
	output logic             irq_o,
	output logic             alt_vector_table_select_o,
	output logic [15:0]      vector_table_base_o
);

	// ==========================================================================
	// submodules
	icf_evt_if evt ();

	icf_edge_detect u_edge (
		.clock_i   (clock_i),
		.sys_rst_i (sys_rst_i),
		.evt       (evt)
	);

	icf_irq_bank u_irq (
		.clock_i   (clock_i),
		.sys_rst_i (sys_rst_i),
		.evt       (evt)
	);

	// ==========================================================================
	// axi write channels: address and data are taken in either order
	logic        aw_held;
	logic        w_held;
	logic [7:0]  aw_addr;
	logic [15:0] w_data;
	logic [1:0]  w_strb;
	logic        wr_fire;
	icf_sel_type wr_sel;

	// one write in flight: new beats are taken at once but do not fire until the response has gone
	always_comb begin
		s_axi_awready_o = !aw_held;
		s_axi_wready_o  = !w_held;
		wr_fire         = aw_held && w_held && !s_axi_bvalid_o;
		wr_sel          = icf_decode(aw_addr);
	end

	// address holding register
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			aw_held <= 1'b0;
			aw_addr <= 8'h00;
		end else if (s_axi_awvalid_i && !aw_held) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr_i;
		end else if (wr_fire) begin
			aw_held <= 1'b0;
		end
	end

	// data holding register; only the low half-word is backed by storage
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			w_held <= 1'b0;
			w_data <= 16'h0000;
			w_strb <= 2'h0;
		end else if (s_axi_wvalid_i && !w_held) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata_i[15:0];
			w_strb <= s_axi_wstrb_i[1:0];
		end else if (wr_fire) begin
			w_held <= 1'b0;
		end
	end

	// write response, slverr for an unmapped offset
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o  <= RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid_o <= 1'b1;
			s_axi_bresp_o  <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_bready_i) begin
			s_axi_bvalid_o <= 1'b0;
		end
	end

	// ==========================================================================
	// control register
	logic [15:0] ctrl_rw;
	logic [15:0] ctrl_rd;

	// only the alt select and polarity bits are storage
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ctrl_rw <= CTRL_RESET;
		end else if (wr_fire && wr_sel == SEL_CTRL) begin
			ctrl_rw <= icf_merge(ctrl_rw, w_data, w_strb) & CTRL_WR_MASK;
		end
	end

	// disable status is read-only and live from the core
	always_comb begin
		ctrl_rd                = ctrl_rw;
		ctrl_rd[CTRL_DIS_BIT]  = disable_instr_active_i;
	end

	// polarity bits steer the edge detector directly
	always_comb begin
		evt.pin = ext_irq_pin_i;
		evt.pol = ctrl_rw[CTRL_POL_LSB +: EXT_IRQ_COUNT];
		ext_irq_event_o = evt.edge_evt;
	end

	// ==========================================================================
	// request flags
	logic [15:0] flags;
	logic [15:0] flag_set;
	logic [15:0] next_flags;

	// pin zero's edge lands in the flag register, the others only in status
	always_comb begin
		flag_set                = periph_event_i & FLAG_SRC_MASK;
		flag_set[FLAG_EXT0_BIT] = evt.edge_evt[0];
		next_flags              = flags;
		if (wr_fire && wr_sel == SEL_FLAGS) begin
			next_flags = icf_merge(flags, w_data, w_strb);
		end
		// a request in the write cycle survives a software clear
		next_flags = (next_flags | flag_set) & FLAG_IMPL_MASK;
	end

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			flags <= FLAGS_RESET;
		end else begin
			flags <= next_flags;
		end
	end

	// ==========================================================================
	// interrupt status and mask
	always_comb begin
		evt.evt_set                = flag_set;
		evt.evt_set[STAT_EXT1_BIT] = evt.edge_evt[1];
		evt.evt_set[STAT_EXT2_BIT] = evt.edge_evt[2];
		evt.w1c                    = 16'h0000;
		if (wr_fire && wr_sel == SEL_STATUS) begin
			evt.w1c = icf_merge(16'h0000, w_data, w_strb);
		end
		evt.mask_wr   = wr_fire && (wr_sel == SEL_MASK);
		evt.mask_data = icf_merge(evt.mask, w_data, w_strb);
		irq_o         = evt.irq;
	end

	// ==========================================================================
	// vector table selection, registered so the core sees a clean value
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			vector_table_base_o <= STD_VEC_BASE;
		end else begin
			vector_table_base_o <= ctrl_rw[CTRL_ALT_BIT] ? ALT_VEC_BASE : STD_VEC_BASE;
		end
	end

	always_comb begin
		alt_vector_table_select_o = ctrl_rw[CTRL_ALT_BIT];
	end

	// ==========================================================================
	// axi read channel: answer one cycle after the address is taken
	icf_sel_type rd_sel;
	logic [15:0] rd_val;

	always_comb begin
		s_axi_arready_o = !s_axi_rvalid_o;
		rd_sel          = icf_decode(s_axi_araddr_i);
		case (rd_sel)
			SEL_CTRL:   rd_val = ctrl_rd;
			SEL_FLAGS:  rd_val = flags;
			SEL_STATUS: rd_val = evt.status;
			SEL_MASK:   rd_val = evt.mask;
			default:    rd_val = 16'h0000;
		endcase
	end

	// upper half-word always reads zero; reads have no side effects
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o  <= 32'h0000_0000;
			s_axi_rresp_o  <= RESP_OKAY;
		end else if (s_axi_arvalid_i && !s_axi_rvalid_o) begin
			s_axi_rvalid_o <= 1'b1;
			s_axi_rdata_o  <= {16'h0000, rd_val};
			s_axi_rresp_o  <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
		end
	end

	// ==========================================================================
	// checks
	chk_ctrl_alt_write: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		(wr_fire && wr_sel == SEL_CTRL && w_strb[1])
		|=> (ctrl_rd[13:3] == 11'h000) && (ctrl_rw[CTRL_ALT_BIT] == $past(w_data[15])))
		else $error("control write not stored as laid out");
	chk_flag_unimpl_zero: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		(flags[15:14] == 2'b00) && (flags[4] == 1'b0))
		else $error("unimplemented flag bit set");
	chk_flag_sets: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		periph_event_i[13] |=> flags[13])
		else $error("converter request not flagged");
	chk_vector_select: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		alt_vector_table_select_o ##1 alt_vector_table_select_o
		|-> vector_table_base_o == ALT_VEC_BASE)
		else $error("alternate vector table not selected");
	chk_write_answer: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		(aw_held && w_held && !s_axi_bvalid_o) |=> s_axi_bvalid_o)
		else $error("write response missing");

	// ==========================================================================
	// bus handshake, read-back, flag, status and vector table checks

	// a taken read address is answered in the next cycle
	chk_read_answer: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		(s_axi_arvalid_i && s_axi_arready_o) |=> s_axi_rvalid_o)
		else $error("read answer missing");

	// answers drop once the master has taken them, so arready comes back for the next read
	chk_read_release: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		(s_axi_rvalid_o && s_axi_rready_i) |=> !s_axi_rvalid_o)
		else $error("read answer not released");
	chk_write_release: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		(s_axi_bvalid_o && s_axi_bready_i) |=> !s_axi_bvalid_o)
		else $error("write answer not released");

	// unimplemented control bits and the upper half-word read zero
	chk_ctrl_read_zero: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		(s_axi_arvalid_i && s_axi_arready_o && rd_sel == SEL_CTRL)
		|=> (s_axi_rdata_o[13:3] == 11'h000) && (s_axi_rdata_o[31:16] == 16'h0000))
		else $error("unimplemented control bits read non-zero");

	// disable status is sampled at the edge that takes the read address
	chk_ctrl_dis_read: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		(s_axi_arvalid_i && s_axi_arready_o && rd_sel == SEL_CTRL)
		|=> s_axi_rdata_o[CTRL_DIS_BIT] == $past(disable_instr_active_i))
		else $error("disable status not read back live");

	// a full-word flag write with no request pending lands as written in the implemented bits
	chk_flag_write: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		(wr_fire && wr_sel == SEL_FLAGS && w_strb == 2'b11 && flag_set == 16'h0000)
		|=> flags == ($past(w_data) & FLAG_IMPL_MASK))
		else $error("flag write not stored as laid out");

	// pin zero's edge shows in the flag register one cycle later
	chk_flag_ext_zero: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		evt.edge_evt[0] |=> flags[FLAG_EXT0_BIT])
		else $error("pin zero request not flagged");

	// pin one has no flag bit, so its event must be held in status
	chk_status_ext_one: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		evt.edge_evt[1] |=> evt.status[STAT_EXT1_BIT])
		else $error("pin one event not held in status");

	// standard table while the select bit stays clear
	chk_vector_std: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		!alt_vector_table_select_o ##1 !alt_vector_table_select_o
		|-> vector_table_base_o == STD_VEC_BASE)
		else $error("standard vector table not selected");

endmodule

`default_nettype wire

// *** dv/icf_pin_model.sv ***
// board pins and core status level standing in for the far side of the block
`default_nettype none

module icf_pin_model (
	// clock and reset
	input  wire logic       clock_i,
	input  wire logic       sys_rst_i,
	// levels the bench asks for
	input  wire logic [2:0] level_i,
	input  wire logic       dis_level_i,
	// lines towards the block
	output logic [2:0]      ext_irq_pin_o,
	output logic            disable_instr_active_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// pins move just after an edge, so every change lasts whole clock cycles
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ext_irq_pin_o          <= 3'h0;
			disable_instr_active_o <= 1'b0;
		end else begin
			ext_irq_pin_o          <= level_i;
			disable_instr_active_o <= dis_level_i;
		end
	end
endmodule

`default_nettype wire

// *** dv/test_icf_top.sv ***
// self-checking bench for the interrupt control and flags block
`default_nettype none

module test_icf_top
	import icf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================================
	// signals
	localparam logic [15:0] STD_B = 16'h0200;
	localparam logic [15:0] ALT_B = 16'h0300;
	logic        clock_i, sys_rst_i, awvalid, wvalid, bready, arvalid, rready, dis_lvl;
	logic        awready, wready, bvalid, arready, rvalid, irq, alt;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, seed;
	logic [3:0]  wstrb;
	logic [15:0] periph, vbase;
	logic [2:0]  level, evt;
	logic [1:0]  bresp, rresp;
	wire logic [2:0] pin;
	wire logic   dis_pin;
	int          n_mismatch = 0;
	int          total_checks = 0;
	int          cyc = 0;
	int          evcnt [3] = '{0, 0, 0};

	// clock at 50 MHz
	initial begin
		clock_i = 1'b0;
		forever #10 clock_i = ~clock_i;
	end

	icf_pin_model icf_pin_model_inst (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .level_i(level),
		.dis_level_i(dis_lvl), .ext_irq_pin_o(pin), .disable_instr_active_o(dis_pin));

	icf_top #(.STD_VEC_BASE(STD_B), .ALT_VEC_BASE(ALT_B)) icf_top_inst (
		.clock_i(clock_i), .sys_rst_i(sys_rst_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .ext_irq_pin_i(pin),
		.periph_event_i(periph), .disable_instr_active_i(dis_pin), .ext_irq_event_o(evt),
		.irq_o(irq), .alt_vector_table_select_o(alt), .vector_table_base_o(vbase));

	// ==========================================================================
	// helpers
	// event pulses are counted per cycle, so a pulse two cycles long counts twice
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		for (int i = 0; i < 3; i++)
			evcnt[i] <= evcnt[i] + int'(evt[i]);
		if (cyc == 20000) begin
			n_mismatch++;
			conclude();
		end
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic [15:0] exp_ctrl(input logic [15:0] w, input logic d);
		return (w & 16'h8007) | {1'b0, d, 14'h0};
	endfunction

	function automatic logic [15:0] exp_flag(input logic [15:0] w);
		return w & 16'h3fef;
	endfunction

	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic cmp_bit(input logic got, input logic exp, input string what);
		cmp_word({31'h0, got}, {31'h0, exp}, what);
	endtask

	// one write: address and data offered together, bready held until bvalid
	// no local limit: only the bench timeout ends a wait
	task automatic axi_wr(input logic [7:0] a, input logic [15:0] d, output logic [1:0] r);
		@(posedge clock_i);
		awaddr  <= a;
		wdata   <= {16'h0, d};
		wstrb   <= 4'hf;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge clock_i);
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clock_i);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge clock_i);
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [1:0] r;
		axi_wr(a, d, r);
		cmp_word({30'h0, r}, {30'h0, RESP_OKAY}, "bresp");
	endtask

	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		axi_rd(a, d, r);
		cmp_word({30'h0, r}, {30'h0, RESP_OKAY}, "rresp");
		cmp_word(d, {16'h0, e}, "rdata");
	endtask

	// active edge gives one event and a status bit, the opposite edge gives none
	task automatic pin_case(input int i, input logic pol);
		int          c;
		logic [15:0] sbit;
		sbit = (i == 0) ? 16'h0001 : 16'h0001 << (13 + i);
		wr(CTRL_OFFSET, 16'(pol) << i);
		level[i] <= pol;
		repeat (8) @(posedge clock_i);
		wr(STATUS_OFFSET, 16'hffff);
		wr(FLAGS_OFFSET, 16'h0000);
		c = evcnt[i];
		level[i] <= ~pol;
		repeat (8) @(posedge clock_i);
		cmp_word(32'(evcnt[i] - c), 32'h1, "edge seen");
		rd(STATUS_OFFSET, sbit);
		rd(FLAGS_OFFSET, (i == 0) ? 16'h0001 : 16'h0000);
		level[i] <= pol;
		repeat (8) @(posedge clock_i);
		cmp_word(32'(evcnt[i] - c), 32'h1, "wrong edge");
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ==========================================================================
	// main sequence
	initial begin
		logic [31:0] v, d;
		logic [15:0] w, e;
		logic [1:0]  r;
		seed = 32'h45;
		sys_rst_i <= 1'b1;
		{awvalid, wvalid, bready, arvalid, rready, dis_lvl} <= 6'h0;
		{awaddr, araddr, wstrb, periph, level} <= 39'h0;
		wdata <= 32'h0;
		repeat (12) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		@(posedge clock_i);
		cmp_bit(alt, 1'b0, "alt reset");
		cmp_word({16'h0, vbase}, {16'h0, STD_B}, "base reset");
		rd(CTRL_OFFSET, 16'h0000);
		rd(FLAGS_OFFSET, 16'h0000);
		// bit 14 follows the core level only; writes to it are lost
		for (int k = 0; k < 7; k++) begin
			v = rnd();
			w = (k == 0) ? 16'hffff : (k == 1) ? 16'h7ff8 : (k == 2) ? 16'h8008 : v[15:0];
			dis_lvl <= w[3] ^ w[14];
			wr(CTRL_OFFSET, w);
			rd(CTRL_OFFSET, exp_ctrl(w, w[3] ^ w[14]));
			cmp_bit(alt, w[15], "alt");
			cmp_word({16'h0, vbase}, {16'h0, w[15] ? ALT_B : STD_B}, "base");
		end
		for (int k = 0; k < 8; k++) begin
			v = rnd();
			w = (k == 0) ? 16'hffff : v[15:0];
			wr(FLAGS_OFFSET, w);
			rd(FLAGS_OFFSET, exp_flag(w));
		end
		wr(FLAGS_OFFSET, 16'h0000);
		// peripheral requests pile up; all ones last hits the unused bits
		e = 16'h0000;
		for (int k = 0; k < 8; k++) begin
			v = rnd();
			w = (k == 7) ? 16'hffff : v[15:0] & v[31:16];
			@(posedge clock_i);
			periph <= w;
			@(posedge clock_i);
			periph <= 16'h0000;
			e = e | (w & 16'h3fee);
			rd(FLAGS_OFFSET, e);
		end
		rd(STATUS_OFFSET, e);
		cmp_bit(irq, 1'b0, "irq masked");
		wr(MASK_OFFSET, 16'h0002);
		cmp_bit(irq, 1'b1, "irq raised");
		wr(STATUS_OFFSET, 16'h0002);
		rd(STATUS_OFFSET, e & 16'hfffd);
		cmp_bit(irq, 1'b0, "irq cleared");
		wr(MASK_OFFSET, 16'hffff);
		rd(MASK_OFFSET, STATUS_IMPL_MASK);
		cmp_bit(irq, 1'b1, "irq other");
		wr(STATUS_OFFSET, 16'hffff);
		cmp_bit(irq, 1'b0, "irq all clear");
		// unmapped place answers with an error and stores nothing
		axi_wr(8'h10, 16'hffff, r);
		cmp_word({30'h0, r}, {30'h0, RESP_SLVERR}, "bresp unmapped");
		axi_rd(8'h10, d, r);
		cmp_word({30'h0, r}, {30'h0, RESP_SLVERR}, "rresp unmapped");
		cmp_word(d, 32'h0, "rdata unmapped");
		for (int i = 0; i < 3; i++) begin
			pin_case(i, 1'b0);
			pin_case(i, 1'b1);
		end
		conclude();
	end
endmodule

`default_nettype wire
